// ==== bench/vectored_interrupt_controller_tb.sv ====
// self-checking bench for the interrupt controller
// assumes vic_top and vic_prog_mem are compiled before it
`timescale 1ns/10ps
module vectored_interrupt_controller_tb import vic_pkg::*; ;
  logic        clk  = 1'b0;  // core clock
  logic        rstn = 1'b0;  // reset, active low
  logic [14:0] req  = '0;    // source pulses
  logic        wr   = 1'b0;  // write strobe
  logic [7:0]  addr = '0;    // register address
  logic [7:0]  wd   = '0;    // write data
  logic [3:0]  ins  = '0;    // retire, enable, disable, return
  logic [7:0]  d;            // read result
  logic [14:0] pend;         // expected pending bits
  logic [7:0]  pdat, rdat;   // program byte, read data
  logic        hold, ppl, pph, pfl, vf, br, me; // sequencer outputs
  logic [15:0] va, bt;       // vector address, target
  int          n_fail = 0;
  int          checks = 0;
  int          r;
  vic_top u_vic_top (.CORE_CLK(clk), .RESETN(rstn), .REQ_PULSE(req), .REG_WR(wr), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_RDATA(rdat), .INSTR_RETIRE(ins[0]), .GLOBAL_ENABLE_INSTR(ins[1]),
    .GLOBAL_DISABLE_INSTR(ins[2]), .HANDLER_RETURN_INSTR(ins[3]), .PROG_DATA(pdat), .INT_HOLD(hold),
    .PUSH_PCL(ppl), .PUSH_PCH(pph), .PUSH_FLAGS(pfl), .VEC_FETCH(vf), .VEC_ADDR(va), .BRANCH(br),
    .BRANCH_TARGET(bt), .MASTER_ENABLE(me));
  vic_prog_mem u_vic_prog_mem (.VEC_FETCH(vf), .VEC_ADDR(va), .PROG_DATA(pdat));
  ////////////////////////////////////////////////////////////////
  // 200 MHz core clock
  initial forever #2.5 clk = ~clk;
  // expected vector byte at an address
  function logic [7:0] pm(input logic [15:0] a);
    return (a[7:0] * 8'h1d) ^ 8'ha5;
  endfunction
  // lowest set index wins
  function int low(input logic [14:0] p);
    for (int i = 0; i < 15; i++) if (p[i]) return i;
    return 15;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // all tasks start and end just after a rising edge; each sets every strobe at its start,
  // so back-to-back calls never assign one strobe twice in a time step
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    wr = 1'b1; ins = '0; addr = a; wd = v;
    @(posedge clk); #1;
  endtask
  task rd(input logic [7:0] a);
    wr = 1'b0; ins = '0; addr = a;
    @(posedge clk); #1 d = rdat;
  endtask
  task pulse(input logic [3:0] v);
    wr = 1'b0; ins = v;
    @(posedge clk); #1;
  endtask
  // one vectored service, cycle by cycle
  task serve(input int l);
    pulse(4'h1); ins = '0; chk(hold, 1'b1);
    @(posedge clk); #1 chk(ppl, 1'b1);
    @(posedge clk); #1 chk({pph, me}, 2'b10);
    @(posedge clk); #1 chk(pfl, 1'b1);
    @(posedge clk); #1 chk({vf, va}, {1'b1, 16'(2 + 2 * l)});
    @(posedge clk); #1 chk({vf, va}, {1'b1, 16'(3 + 2 * l)});
    @(posedge clk); #1 chk(br, 1'b1);
    @(posedge clk); #1 chk(bt, {pm(16'(2 + 2 * l)), pm(16'(3 + 2 * l))});
  endtask
  task wrap_up;
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(32'h1076);
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // reset values, plus one unmapped place
    for (int a = 247; a < 252; a++) begin rd(8'(a)); chk(d, 0); end
    // read back random data; reserved pending bit stays zero
    for (int a = 248; a < 252; a++) begin
      r = $urandom & ((a == 251) ? 32'h7f : 32'hff);
      wr_reg(8'(a), 8'(r)); rd(8'(a));
      chk(d, (a == 250) ? (r & 32'h7f) : r);
      wr_reg(8'(a), 8'h00);
    end
    wr_reg(8'hf7, 8'hff); rd(8'hf7); chk(d, 0);
    // masked sources latch but never vector
    pend = 15'($urandom) | 15'h0001;
    req = pend; @(posedge clk); #1 req = '0;
    rd(8'hfa); chk(d, {1'b0, pend[6:0]});
    rd(8'hf8); chk(d, pend[14:7]);
    pulse(4'h2); pulse(4'h1); chk(hold, 1'b0);
    // software write beats a same-cycle source set
    req = 15'h0001; wr_reg(8'hfa, 8'h00); req = '0;
    rd(8'hfa); chk(d, 0);
    wr_reg(8'hf8, 8'h00); pulse(4'h4);
    // software-raised requests served in fixed priority
    for (int k = 0; k < 4; k++) begin
      pend = (k == 0) ? 15'h7fff : (k == 1) ? 15'h4000 : 15'($urandom) | 15'h0100;
      wr_reg(8'hf8, pend[14:7]); wr_reg(8'hfa, {1'b0, pend[6:0]});
      wr_reg(8'hf9, 8'hff); wr_reg(8'hfb, 8'h7f);
      pulse(4'h2); pulse(4'h4); pulse(4'h1); chk(hold, 1'b0);
      chk(me, 1'b0);
      pulse(4'h2);
      while (pend != 0) begin
        serve(low(pend));
        pend[low(pend)] = 1'b0;
        rd(8'hfa); chk(d, {1'b0, pend[6:0]});
        rd(8'hf8); chk(d, pend[14:7]);
        pulse(4'h8); chk(me, 1'b1);
      end
      pulse(4'h4); wr_reg(8'hfb, 8'h00);
    end
    // reset in mid-run clears what software left behind
    wr_reg(8'hf9, 8'h5a); wr_reg(8'hf8, 8'hc3); wr_reg(8'hfa, 8'h11);
    wr = 1'b0; rstn = 1'b0;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (int a = 248; a < 252; a++) begin rd(8'(a)); chk(d, 0); end
    chk({hold, me}, 2'b00);
    wrap_up;
  end
endmodule

// ==== bench/vic_prog_mem.sv ====
// program memory stand-in: returns one vector byte per address
// assumes the controller only trusts PROG_DATA while VEC_FETCH is high
`timescale 1ns/10ps
module vic_prog_mem
  import vic_pkg::*;
(
  // fetch request
  input  wire logic        VEC_FETCH,
  input  wire logic [15:0] VEC_ADDR,
  // returned byte
  output logic [7:0]       PROG_DATA
);
  logic [7:0] junk_q = 8'h3c; // undriven bus pattern
  ////////////////////////////////////////////////////////////////
  // the bus is not held between fetches, so show a moving pattern
  always #3 junk_q = ~junk_q;
  // each address gives its own byte, so every level has its own target
  assign PROG_DATA = VEC_FETCH ? ((VEC_ADDR[7:0] * 8'h1d) ^ 8'ha5) : junk_q;
endmodule

// ==== design/vic_pkg.sv ====
// constants for the vectored interrupt controller
// assumes a single core clock; register addresses are core register-file bytes
package vic_pkg;
  localparam int          VIC_NREQ       = 15;
  localparam logic [7:0]  ADDR_PEND_HIGH = 8'hf8;
  localparam logic [7:0]  ADDR_EN_HIGH   = 8'hf9;
  localparam logic [7:0]  ADDR_PEND_LOW  = 8'hfa;
  localparam logic [7:0]  ADDR_EN_LOW    = 8'hfb;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int          MASTER_BIT     = 7;
  localparam logic [15:0] VECTOR_BASE    = 16'h0002;
  // service sequence states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEL   = 3'b001,
    ST_PUSHL = 3'b010,
    ST_PUSHH = 3'b011,
    ST_PUSHF = 3'b100,
    ST_VECH  = 3'b101,
    ST_VECL  = 3'b110,
    ST_JUMP  = 3'b111
  } vic_state_t;
endpackage

// ==== design/vic_prio.sv ====
// fixed priority picker: lowest index wins
// assumes the caller registers the outputs if timing needs it
`timescale 1ns/10ps
module vic_prio
  import vic_pkg::*;
#(
  parameter int N = VIC_NREQ
) (
  // candidates
  input  wire logic [N-1:0] cand,
  // result
  output logic              any,
  output logic [3:0]        idx
);
  // elaboration check: the index port is four bits wide
  if (N < 1 || N > 16) begin : g_bad_n
    $error("vic_prio: N out of range");
  end
  // scan from the top down so the lowest index is the last writer
  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule

// ==== design/vic_top.sv ====
// interrupt controller: mask/request registers and service sequencer
// assumes the core issues register accesses, retire strobes and instruction strobes on CORE_CLK
`timescale 1ns/10ps
module vic_top
  import vic_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  // request sources, one-cycle pulses
  input  wire logic [14:0] REQ_PULSE,
  // register file port
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic [7:0]       REG_RDATA,
  // instruction sequencer
  input  wire logic        INSTR_RETIRE,
  input  wire logic        GLOBAL_ENABLE_INSTR,
  input  wire logic        GLOBAL_DISABLE_INSTR,
  input  wire logic        HANDLER_RETURN_INSTR,
  input  wire logic [7:0]  PROG_DATA,
  output logic             INT_HOLD,
  output logic             PUSH_PCL,
  output logic             PUSH_PCH,
  output logic             PUSH_FLAGS,
  output logic             VEC_FETCH,
  output logic [15:0]      VEC_ADDR,
  output logic             BRANCH,
  output logic [15:0]      BRANCH_TARGET,
  output logic             MASTER_ENABLE
);

  ////////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  logic rst_meta_q; // first stage, read only by second
  logic rst_n;      // synchronised reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0]  en_low;    // request_enable_low, bit7 master
    logic [7:0]  en_high;   // request_enable_high
    logic [7:0]  pend_low;  // pending_requests_low
    logic [7:0]  pend_high; // pending_requests_high
    vic_state_t  st;        // service sequencer
    logic [3:0]  lvl;       // level in service
    logic [7:0]  vhi;       // vector high byte
    logic [7:0]  rdata;     // registered read data
    logic [15:0] target;    // branch target
    logic [15:0] vaddr;     // vector fetch address, registered
  } vic_regs_t;

  vic_regs_t s_q;
  vic_regs_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // gating and priority
  logic [14:0] pend_all; // pending, all levels
  logic [14:0] en_all;   // individual enables
  logic [14:0] cand;     // eligible requests
  logic        any;      // something eligible
  logic [3:0]  win;      // winning level

  assign pend_all = {s_q.pend_high, s_q.pend_low[6:0]};
  assign en_all   = {s_q.en_high, s_q.en_low[6:0]};
  // master, individual enable and pending all required
  assign cand = s_q.en_low[MASTER_BIT] ? (pend_all & en_all) : 15'h0000;

  vic_prio #(
    .N (VIC_NREQ)
  ) u_prio (
    .cand (cand),
    .any  (any),
    .idx  (win)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state
  logic [14:0] clr_acc; // pending bit cleared on acceptance
  logic [15:0] vloc;    // vector location of the selected level
  always_comb begin
    s_d     = s_q;
    clr_acc = 15'h0000;
    vloc    = VECTOR_BASE + {11'h000, s_q.lvl, 1'b0};
    // master enable instructions
    if (GLOBAL_ENABLE_INSTR || HANDLER_RETURN_INSTR) begin
      s_d.en_low[MASTER_BIT] = 1'b1;
    end else if (GLOBAL_DISABLE_INSTR) begin
      s_d.en_low[MASTER_BIT] = 1'b0;
    end
    // sequencer
    unique case (s_q.st)
      ST_IDLE: begin
        // sample only as an instruction retires
        if (INSTR_RETIRE && any) begin
          s_d.st = ST_SEL;
        end
      end
      ST_SEL: begin
        // selection cycle: no instruction runs
        if (any) begin
          s_d.lvl = win;
          s_d.st  = ST_PUSHL;
        end else begin
          s_d.st = ST_IDLE;
        end
      end
      ST_PUSHL: begin
        // accept: clear pending bit and master as pushing starts
        clr_acc                = 15'(1) << s_q.lvl;
        s_d.en_low[MASTER_BIT] = 1'b0;
        s_d.st                 = ST_PUSHH;
      end
      ST_PUSHH: s_d.st = ST_PUSHF;
      ST_PUSHF: begin
        // fetch address leaves a flop, not an adder
        s_d.vaddr = vloc;
        s_d.st    = ST_VECH;
      end
      ST_VECH: begin
        s_d.vhi   = PROG_DATA;
        s_d.vaddr = vloc + 16'h0001;
        s_d.st    = ST_VECL;
      end
      ST_VECL: begin
        s_d.target = {s_q.vhi, PROG_DATA};
        s_d.st     = ST_JUMP;
      end
      ST_JUMP: s_d.st = ST_IDLE;
    endcase
    // hardware sets after the accept clear: a new pulse in the accept cycle is kept
    s_d.pend_low[6:0] = (s_q.pend_low[6:0] & ~clr_acc[6:0]) | REQ_PULSE[6:0];
    s_d.pend_high     = (s_q.pend_high & ~clr_acc[14:7]) | REQ_PULSE[14:7];
    // register writes win over everything else
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_EN_LOW:    s_d.en_low    = REG_WDATA;
        ADDR_EN_HIGH:   s_d.en_high   = REG_WDATA;
        ADDR_PEND_LOW:  s_d.pend_low  = {1'b0, REG_WDATA[6:0]};
        ADDR_PEND_HIGH: s_d.pend_high = REG_WDATA;
        default: ;
      endcase
    end
    // read data, one cycle after the address
    unique case (REG_ADDR)
      ADDR_EN_LOW:    s_d.rdata = s_q.en_low;
      ADDR_EN_HIGH:   s_d.rdata = s_q.en_high;
      ADDR_PEND_LOW:  s_d.rdata = s_q.pend_low;
      ADDR_PEND_HIGH: s_d.rdata = s_q.pend_high;
      default:        s_d.rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // data outputs come from the state register; strobes are state decodes
  assign REG_RDATA     = s_q.rdata;
  assign INT_HOLD      = (s_q.st != ST_IDLE);
  assign PUSH_PCL      = (s_q.st == ST_PUSHL);
  assign PUSH_PCH      = (s_q.st == ST_PUSHH);
  assign PUSH_FLAGS    = (s_q.st == ST_PUSHF);
  assign VEC_FETCH     = (s_q.st == ST_VECH) || (s_q.st == ST_VECL);
  assign VEC_ADDR      = s_q.vaddr;
  assign BRANCH        = (s_q.st == ST_JUMP);
  assign BRANCH_TARGET = s_q.target;
  assign MASTER_ENABLE = s_q.en_low[MASTER_BIT];

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_master_gate;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.st == ST_IDLE && !MASTER_ENABLE) |=> !INT_HOLD;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("request eligible with master off");

  property p_seq_order;
    @(posedge CORE_CLK) disable iff (!rst_n)
      PUSH_PCL |=> PUSH_PCH ##1 PUSH_FLAGS ##1 (VEC_FETCH && VEC_ADDR == vloc) ##1 VEC_FETCH ##1 BRANCH;
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("service sequence out of order");

  property p_accept_clear;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (PUSH_PCL && !REG_WR && !GLOBAL_ENABLE_INSTR && !HANDLER_RETURN_INSTR) |=> !MASTER_ENABLE;
  endproperty
  a_accept_clear: assert property (p_accept_clear) else $error("master not cleared on accept");

  property p_hw_latch;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (REQ_PULSE[0] && !REG_WR) |=> s_q.pend_low[0];
  endproperty
  a_hw_latch: assert property (p_hw_latch) else $error("request not latched");

  property p_sw_wins;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (REG_WR && REG_ADDR == ADDR_PEND_HIGH) |=> s_q.pend_high == $past(REG_WDATA);
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("software write lost");

  property p_reserved;
    @(posedge CORE_CLK) disable iff (!rst_n) !s_q.pend_low[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_retire_sel;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.st == ST_IDLE && INSTR_RETIRE && any) |=> INT_HOLD ##1 (PUSH_PCL || !INT_HOLD);
  endproperty
  a_retire_sel: assert property (p_retire_sel) else $error("selection cycle missing");

  property p_prio;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.st == ST_SEL && cand[0]) |=> s_q.lvl == 4'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");

  // the selected level is still pending and enabled when pushing starts
  property p_sel_enabled;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.st == ST_SEL && any && !REG_WR) |=> (pend_all[s_q.lvl] && en_all[s_q.lvl]);
  endproperty
  a_sel_enabled: assert property (p_sel_enabled) else $error("selected level not eligible");

  // only high levels eligible: the chosen level is one of them
  property p_level_high;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.st == ST_SEL && any && cand[6:0] == 7'h00) |=> (s_q.lvl >= 4'h7);
  endproperty
  a_level_high: assert property (p_level_high) else $error("high level not chosen");

  // the winner is the lowest eligible level, checked apart from the picker
  property p_lowest_wins;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.st == ST_SEL && any) |=> (($past(cand) & ((15'(1) << s_q.lvl) - 15'(1))) == 15'h0000);
  endproperty
  a_lowest_wins: assert property (p_lowest_wins) else $error("lower eligible level skipped");

  // return instruction turns the master back on
  property p_return_sets;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (HANDLER_RETURN_INSTR && !REG_WR && !PUSH_PCL) |=> MASTER_ENABLE;
  endproperty
  a_return_sets: assert property (p_return_sets) else $error("master not set by return");

  // disable instruction alone turns the master off
  property p_disable_clears;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (GLOBAL_DISABLE_INSTR && !GLOBAL_ENABLE_INSTR && !HANDLER_RETURN_INSTR && !REG_WR) |=> !MASTER_ENABLE;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("master not cleared by disable");

  // a masked source still latches, ready for polling
  property p_mask_latch;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (REQ_PULSE[7] && !s_q.en_high[0] && !REG_WR) |=> s_q.pend_high[0];
  endproperty
  a_mask_latch: assert property (p_mask_latch) else $error("masked request not latched");

  // a pending bit stays until serviced or written
  property p_pend_hold;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.pend_low[3] && !REG_WR && !(PUSH_PCL && s_q.lvl == 4'h3)) |=> s_q.pend_low[3];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending bit lost");

  // software writes the low pending bits exactly, reserved bit forced low
  property p_sw_low;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (REG_WR && REG_ADDR == ADDR_PEND_LOW) |=> (s_q.pend_low == {1'b0, $past(REG_WDATA[6:0])});
  endproperty
  a_sw_low: assert property (p_sw_low) else $error("software request not stored");

  // vector bytes come from the level's own pair of locations
  property p_vec_pair;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (s_q.st == ST_VECH) |-> (VEC_ADDR == VECTOR_BASE + {11'h000, s_q.lvl, 1'b0})
        ##1 (VEC_ADDR == VECTOR_BASE + {11'h000, s_q.lvl, 1'b1});
  endproperty
  a_vec_pair: assert property (p_vec_pair) else $error("vector location wrong");

  // main scenarios
  c_service: cover property (@(posedge CORE_CLK) disable iff (!rst_n) PUSH_PCL ##5 BRANCH);
  c_sw_req:  cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    (REG_WR && REG_ADDR == ADDR_PEND_LOW) ##[1:3] PUSH_PCL);
  c_clash:   cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    REG_WR && REG_ADDR == ADDR_PEND_LOW && REQ_PULSE[0]);
  c_last_level: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    PUSH_PCL && s_q.lvl == 4'he);
  c_gated_off:  cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    INSTR_RETIRE && !MASTER_ENABLE && ((pend_all & en_all) != 15'h0000));
endmodule
